// ==== logic/acalu_pkg.sv ====
package acalu_pkg;
  localparam int unsigned ACALU_W = 8;
  localparam logic [7:0] ACALU_OP_ADD_IMM       = 8'h24;
  localparam logic [7:0] ACALU_OP_ADD_DIR       = 8'h25;
  localparam logic [6:0] ACALU_OP_ADD_IND_BASE  = 7'h13;
  localparam logic [4:0] ACALU_OP_ADD_REG_BASE  = 5'h05;
  localparam logic [7:0] ACALU_OP_ADD_WITH_CARRY_INSTR_IMM      = 8'h34;
  localparam logic [7:0] ACALU_OP_ADD_WITH_CARRY_INSTR_DIR      = 8'h35;
  localparam logic [6:0] ACALU_OP_ADD_WITH_CARRY_INSTR_IND_BASE = 7'h1b;
  localparam logic [4:0] ACALU_OP_ADD_WITH_CARRY_INSTR_REG_BASE = 5'h07;
  localparam logic [7:0] ACALU_ACC_RST          = 8'h00;
  localparam int unsigned ACALU_HALF_BIT        = 3;
  localparam int unsigned ACALU_SIGN_BIT        = 7;
  localparam int unsigned ACALU_SUB6_BIT        = 6;
  typedef enum logic [1:0] {ACALU_SRC_REG, ACALU_SRC_DIR, ACALU_SRC_IND, ACALU_SRC_IMM} acalu_src_t;
endpackage : acalu_pkg

// ==== logic/acalu_adder.sv ====
`timescale 1ns/1ps
module acalu_adder
  import acalu_pkg::*;
(
  input  wire logic [7:0] opa,
  input  wire logic [7:0] opb,
  input  wire logic       cin,
  output logic      [7:0] sum,
  output logic            carry_out,
  output logic            half_out,
  output logic            ovf_out
);
  logic [8:0] c;
  assign c[0] = cin;
  // Ripple chain keeps each bit's carry visible for the flags
  genvar gi;
  generate
    for (gi = 0; gi < ACALU_W; gi++)
    begin : g_bit
      assign sum[gi]   = opa[gi] ^ opb[gi] ^ c[gi];
      assign c[gi + 1] = (opa[gi] & opb[gi]) | (c[gi] & (opa[gi] ^ opb[gi]));
    end
  endgenerate
  assign carry_out = c[ACALU_SIGN_BIT + 1];
  assign half_out  = c[ACALU_HALF_BIT + 1];
  assign ovf_out   = c[ACALU_SUB6_BIT + 1] ^ c[ACALU_SIGN_BIT + 1];
endmodule : acalu_adder

// ==== logic/acalu_core.sv ====
`timescale 1ns/1ps
module acalu_core
  import acalu_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       instr_valid,
  input  wire logic [7:0] opcode,
  input  wire logic [7:0] operand_byte,
  input  wire logic [7:0] reg_bank_data,
  input  wire logic [7:0] dir_mem_data,
  input  wire logic [7:0] ind_mem_data,
  input  wire logic [7:0] indirect_pointer_reg0,
  input  wire logic [7:0] indirect_pointer_reg1,
  output logic      [2:0] reg_sel,
  output logic      [7:0] dir_addr,
  output logic      [7:0] ind_addr,
  output logic            instr_taken,
  output logic      [7:0] acc,
  output logic            carry_flag,
  output logic            half_carry_flag,
  output logic            signed_overflow_flag
);
  logic       is_add;
  logic       add_with_carry_instr;
  acalu_src_t src_mode;
  logic [7:0] src_byte;
  logic       cin;
  logic [7:0] sum;
  logic       co;
  logic       ho;
  logic       vo;
  logic [7:0] next_acc;
  logic       next_cy;
  logic       next_ac;
  logic       next_ov;

  always_comb
  begin
    is_add               = 1'b0;
    add_with_carry_instr = 1'b0;
    src_mode             = ACALU_SRC_IMM;
    if (opcode == ACALU_OP_ADD_IMM)
    begin
      is_add = 1'b1;
    end
    else if (opcode == ACALU_OP_ADD_DIR)
    begin
      is_add   = 1'b1;
      src_mode = ACALU_SRC_DIR;
    end
    else if (opcode[7:1] == ACALU_OP_ADD_IND_BASE)
    begin
      is_add   = 1'b1;
      src_mode = ACALU_SRC_IND;
    end
    else if (opcode[7:3] == ACALU_OP_ADD_REG_BASE)
    begin
      is_add   = 1'b1;
      src_mode = ACALU_SRC_REG;
    end
    else if (opcode == ACALU_OP_ADD_WITH_CARRY_INSTR_IMM)
    begin
      add_with_carry_instr = 1'b1;
    end
    else if (opcode == ACALU_OP_ADD_WITH_CARRY_INSTR_DIR)
    begin
      add_with_carry_instr = 1'b1;
      src_mode             = ACALU_SRC_DIR;
    end
    else if (opcode[7:1] == ACALU_OP_ADD_WITH_CARRY_INSTR_IND_BASE)
    begin
      add_with_carry_instr = 1'b1;
      src_mode             = ACALU_SRC_IND;
    end
    else if (opcode[7:3] == ACALU_OP_ADD_WITH_CARRY_INSTR_REG_BASE)
    begin
      add_with_carry_instr = 1'b1;
      src_mode             = ACALU_SRC_REG;
    end
  end

  // Address outputs are steered combinationally so memory can answer in-cycle
  assign reg_sel  = opcode[2:0];
  assign dir_addr = operand_byte;
  assign ind_addr = opcode[0] ? indirect_pointer_reg1 : indirect_pointer_reg0;
  assign instr_taken = instr_valid & (is_add | add_with_carry_instr);

  always_comb
  begin
    unique case (src_mode)
      ACALU_SRC_REG: src_byte = reg_bank_data;
      ACALU_SRC_DIR: src_byte = dir_mem_data;
      ACALU_SRC_IND: src_byte = ind_mem_data;
      ACALU_SRC_IMM: src_byte = operand_byte;
    endcase
  end

  assign cin = add_with_carry_instr & carry_flag;

  acalu_adder u_adder (
    .opa       (acc),
    .opb       (src_byte),
    .cin       (cin),
    .sum       (sum),
    .carry_out (co),
    .half_out  (ho),
    .ovf_out   (vo)
  );

  always_comb
  begin
    next_acc = acc;
    next_cy  = carry_flag;
    next_ac  = half_carry_flag;
    next_ov  = signed_overflow_flag;
    if (instr_taken)
    begin
      next_acc = sum;
      next_cy  = co;
      next_ac  = ho;
      next_ov  = vo;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      acc                  <= ACALU_ACC_RST;
      carry_flag           <= 1'b0;
      half_carry_flag      <= 1'b0;
      signed_overflow_flag <= 1'b0;
    end
    else
    begin
      acc                  <= next_acc;
      carry_flag           <= next_cy;
      half_carry_flag      <= next_ac;
      signed_overflow_flag <= next_ov;
    end
  end

  // Reference sum for checking, nine bits wide to keep the carry
  logic [8:0] chk_sum;
  logic [4:0] chk_half;
  logic [7:0] chk_low;
  assign chk_sum  = {1'b0, acc} + {1'b0, src_byte} + {8'h00, cin};
  assign chk_half = {1'b0, acc[3:0]} + {1'b0, src_byte[3:0]} + {4'h0, cin};
  assign chk_low  = {1'b0, acc[6:0]} + {1'b0, src_byte[6:0]} + {7'h00, cin};

  acc_write_a: assert property (@(posedge clk_sys) disable iff (srst)
    instr_taken |=> acc == $past(chk_sum[7:0]))
    else $error("accumulator not loaded with sum");
  carry_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
    instr_taken |=> carry_flag == $past(chk_sum[8]))
    else $error("carry flag wrong");
  half_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
    instr_taken |=> half_carry_flag == $past(chk_half[4]))
    else $error("half carry flag wrong");
  ovf_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
    instr_taken |=> signed_overflow_flag == $past(chk_low[7] ^ chk_sum[8]))
    else $error("overflow flag wrong");
  imm_add_a: assert property (@(posedge clk_sys) disable iff (srst)
    instr_valid && opcode == ACALU_OP_ADD_IMM |=> acc == $past(acc + operand_byte))
    else $error("immediate add wrong");
  plain_nocarry_a: assert property (@(posedge clk_sys) disable iff (srst)
    instr_taken && !opcode[4] |=> acc == $past(acc + src_byte))
    else $error("plain add used carry");
  ptr_sel_a: assert property (@(posedge clk_sys) disable iff (srst)
    instr_valid && (opcode[7:1] == ACALU_OP_ADD_IND_BASE || opcode[7:1] == ACALU_OP_ADD_WITH_CARRY_INSTR_IND_BASE)
    |-> src_byte == ind_mem_data && ind_addr == (opcode[0] ? indirect_pointer_reg1 : indirect_pointer_reg0))
    else $error("wrong pointer");
  src_mux_a: assert property (@(posedge clk_sys) disable iff (srst)
    add_with_carry_instr && opcode[7:3] == ACALU_OP_ADD_WITH_CARRY_INSTR_REG_BASE |-> src_byte == reg_bank_data)
    else $error("register source not selected");
  hold_a: assert property (@(posedge clk_sys) disable iff (srst)
    !instr_taken |=> $stable(acc) && $stable(carry_flag) && $stable(half_carry_flag) && $stable(signed_overflow_flag))
    else $error("state changed without instruction");

  imm_c: cover property (@(posedge clk_sys) instr_taken && src_mode == ACALU_SRC_IMM);
  ind_c: cover property (@(posedge clk_sys) instr_taken && src_mode == ACALU_SRC_IND && opcode[0]);
  ovf_c: cover property (@(posedge clk_sys) instr_taken && vo);
  adc_c: cover property (@(posedge clk_sys) instr_taken && add_with_carry_instr && cin);
endmodule : acalu_core

// ==== tb/acalu_fetch_model.sv ====
`timescale 1ns/1ps
module acalu_fetch_model
  import acalu_pkg::*;
(
  input  wire logic [2:0] reg_sel,
  input  wire logic [7:0] dir_addr,
  input  wire logic [7:0] ind_addr,
  output logic      [7:0] reg_bank_data,
  output logic      [7:0] dir_mem_data,
  output logic      [7:0] ind_mem_data
);
  // Fixed contents from the address, so every fetched byte is predictable
  assign reg_bank_data = {5'h00, reg_sel} ^ 8'haa;
  assign dir_mem_data  = dir_addr ^ 8'h5c;
  assign ind_mem_data  = ind_addr ^ 8'h93;
endmodule : acalu_fetch_model

// ==== tb/accumulator_add_carry_alu_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module accumulator_add_carry_alu_test
  import acalu_pkg::*;
;
  logic       clk_sys = 1'b0, srst = 1'b1, instr_valid = 1'b0;
  logic [7:0] opcode = 8'h00, operand_byte = 8'h00, p0 = 8'h21, p1 = 8'h7e, ea = 8'h00;
  logic [7:0] rd, dd, id, dir_addr, ind_addr, acc;
  logic [2:0] reg_sel;
  logic       instr_taken, cf, hf, vf, ec = 1'b0, eh = 1'b0, ev = 1'b0;
  int         err_total = 0, checks = 0;
  acalu_core acalu_core_i (.clk_sys(clk_sys), .srst(srst), .instr_valid(instr_valid), .opcode(opcode),
    .operand_byte(operand_byte), .reg_bank_data(rd), .dir_mem_data(dd), .ind_mem_data(id),
    .indirect_pointer_reg0(p0), .indirect_pointer_reg1(p1), .reg_sel(reg_sel), .dir_addr(dir_addr),
    .ind_addr(ind_addr), .instr_taken(instr_taken), .acc(acc), .carry_flag(cf), .half_carry_flag(hf),
    .signed_overflow_flag(vf));
  acalu_fetch_model acalu_fetch_model_i (.reg_sel(reg_sel), .dir_addr(dir_addr), .ind_addr(ind_addr),
    .reg_bank_data(rd), .dir_mem_data(dd), .ind_mem_data(id));
  initial forever #2.5 clk_sys = ~clk_sys;
  task end_sim;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task rst(input int n);
    instr_valid = 1'b0;
    srst = 1'b1;
    repeat (n) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    {ea, ec, eh, ev} = 11'h000;
    `CHK({acc, cf, hf, vf}, 11'h000)
  endtask : rst
  // One instruction per cycle; expectations come from the bench's own adder
  task step(input logic [7:0] op, input logic [7:0] d);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] l, b;
    logic       c, tk;
    begin
      instr_valid = 1'b1;
      opcode = op;
      operand_byte = d;
      #1;
      tk = (op[7:5] == 3'h1) && (op[3:2] != 2'h0);
      c = op[4] & ec;
      b = op[3] ? ({5'h00, op[2:0]} ^ 8'haa) : op[1] ? ((op[0] ? p1 : p0) ^ 8'h93) : op[0] ? (d ^ 8'h5c) : d;
      `CHK(instr_taken, tk)
      `CHK({reg_sel, dir_addr}, {op[2:0], d})
      `CHK(ind_addr, op[0] ? p1 : p0)
      @(posedge clk_sys);
      #1;
      if (tk)
      begin
        s = {1'b0, ea} + {1'b0, b} + c;
        h = {1'b0, ea[3:0]} + {1'b0, b[3:0]} + c;
        l = {1'b0, ea[6:0]} + {1'b0, b[6:0]} + c;
        ea = s[7:0];
        ec = s[8];
        eh = h[4];
        ev = l[7] ^ s[8];
      end
      `CHK(acc, ea)
      `CHK({cf, hf}, {ec, eh})
      `CHK(vf, ev)
    end
  endtask : step
  task t_example;
    step(8'h24, 8'hff);
    step(8'h24, 8'hc4);
    step(8'h38, 8'h00);
    `CHK({acc, cf, hf, vf}, {8'h6e, 3'h5})
    $display("t_example done");
  endtask : t_example
  // Every code of both families back to back, refused neighbours included
  task t_modes;
    for (int i = 8'h20; i < 8'h40; i++)
    begin
      if (i == 8'h30) p1 = 8'h0f;
      step(8'(i), 8'(i) ^ 8'h6d);
    end
    $display("t_modes done");
  endtask : t_modes
  // A valid add code with instr_valid low must leave the state alone
  task t_idle;
    instr_valid = 1'b0;
    opcode = 8'h34;
    operand_byte = 8'hff;
    #1;
    `CHK(instr_taken, 1'b0)
    @(posedge clk_sys);
    #1;
    `CHK({acc, cf, hf, vf}, {ea, ec, eh, ev})
    $display("t_idle done");
  endtask : t_idle
  // Reset in mid-run must drop the carry that would feed the next add
  task t_midrst;
    step(8'h24, 8'hff);
    step(8'h34, 8'hff);
    `CHK(cf, 1'b1)
    rst(1);
    step(8'h34, 8'h0f);
    step(8'h34, 8'h01);
    `CHK({acc, cf, hf}, {8'h10, 2'h1})
    $display("t_midrst done");
  endtask : t_midrst
  initial
  begin
    rst(3);
    t_example;
    t_modes;
    t_idle;
    t_midrst;
    end_sim;
  end
  // Tests need about 45 cycles; this bound leaves wide margin
  initial
  begin
    #10000;
    err_total++;
    end_sim;
  end
endmodule : accumulator_add_carry_alu_test
